// ==== rtl/cfs_pkg.sv ====
package cfs_pkg;

  localparam logic [15:0] RESET_PC        = 16'h0000;
  localparam logic [2:0]  IRQ_BLOCK_INSNS = 3'h4;

  // Locations of the core's own registers in the I/O space
  localparam logic [4:0] IO_SP_LOW  = 5'h00;
  localparam logic [4:0] IO_SP_HIGH = 5'h01;
  localparam logic [4:0] IO_SREG    = 5'h02;

  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_I = 7;

  localparam logic [1:0] ALU_ADD = 2'h0;
  localparam logic [1:0] ALU_SUB = 2'h1;
  localparam logic [1:0] ALU_AND = 2'h2;
  localparam logic [1:0] ALU_OR  = 2'h3;

  localparam logic [1:0] MUL_UU = 2'h0;
  localparam logic [1:0] MUL_SS = 2'h1;
  localparam logic [1:0] MUL_SU = 2'h2;

  localparam logic [3:0] FL_INDCALL    = 4'h0;
  localparam logic [3:0] FL_RET        = 4'h1;
  localparam logic [3:0] FL_IRQ_RETURN = 4'h2;
  localparam logic [3:0] FL_JMP        = 4'h3;
  localparam logic [3:0] FL_BRZ        = 4'h4;

  typedef enum logic [3:0] {
    OP_NOP  = 4'h0, OP_ALU = 4'h1, OP_MUL  = 4'h2, OP_FMUL = 4'h3,
    OP_SUBI = 4'h4, OP_ANDI = 4'h5, OP_ORI = 4'h6, OP_LDI  = 4'h7,
    OP_CPI  = 4'h8, OP_PUSH = 4'h9, OP_POP = 4'ha, OP_CALL = 4'hb,
    OP_RELCALL = 4'hc, OP_FLOW = 4'hd, OP_OUT = 4'he, OP_IN = 4'hf
  } cfs_op_type;

  typedef enum logic [3:0] {
    ST_RUN = 4'h0, ST_MUL = 4'h1, ST_FAR = 4'h2, ST_PUSH_LO = 4'h3,
    ST_PUSH_HI = 4'h4, ST_POP_A = 4'h5, ST_POP_WB = 4'h6, ST_RET_A = 4'h7,
    ST_RET_B = 4'h8, ST_RET_C = 4'h9
  } cfs_state_type;

  typedef struct packed {
    cfs_op_type op;
    logic [1:0] sub;
    logic [4:0] rd;
    logic [4:0] rr;
  } cfs_rr_ins_type;

  typedef struct packed {
    cfs_op_type op;
    logic [3:0] rd;
    logic [7:0] k;
  } cfs_imm_ins_type;

  typedef struct packed {
    cfs_op_type op;
    logic [3:0] sub;
    logic [7:0] off;
  } cfs_flow_ins_type;

  typedef struct packed {
    logic signed_a;
    logic signed_b;
    logic frac;
  } cfs_mul_mode_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        re;
  } cfs_dmem_type;

endpackage : cfs_pkg

// ==== rtl/cfs_mult.sv ====
`timescale 1ns/1ns
`default_nettype none
module cfs_mult (
  input  wire logic                      clock,
  input  wire logic                      rst_b,
  input  wire logic                      start,
  input  wire cfs_pkg::cfs_mul_mode_type mode,
  input  wire logic [7:0]                a,
  input  wire logic [7:0]                b,
  output logic [15:0]                    product,
  output logic                           done
);
  typedef struct packed {
    logic        done;
    logic [15:0] prod;
  } cfs_mult_state_type;

  cfs_mult_state_type s_q;
  cfs_mult_state_type s_d;

  logic signed [8:0]  op_a;
  logic signed [8:0]  op_b;
  logic signed [17:0] full;
  logic [15:0]        p;

  always_comb begin
    s_d = s_q;
    // Sign extension picks the operand format
    op_a = {mode.signed_a & a[7], a};
    op_b = {mode.signed_b & b[7], b};
    full = op_a * op_b; // RULE7 RULE8
    p = full[15:0];
    if (mode.frac) begin
      p = {full[14:0], 1'b0}; // RULE8
    end
    s_d.done = start;
    if (start) begin
      s_d.prod = p;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign product = s_q.prod;
  assign done    = s_q.done;

  chk_mult_done: assert property (@(posedge clock) disable iff (!rst_b) // RULE9
    start |=> done && product == $past(p)) else $error("multiplier result late or wrong");

endmodule : cfs_mult
`default_nettype wire

// ==== rtl/cfs_core.sv ====
// Behaviour
// RULE1: After reset fetching starts at word address zero; counter names next fetch.
// RULE2: Next word is prefetched while the current instruction executes.
// RULE3: Core runs straight off the one core clock, no division.
// RULE4: Arithmetic unit reads any of the 32 eight-bit working registers.
// RULE5: Register or immediate arithmetic completes in one cycle with writeback.
// RULE6: Every arithmetic or logic result updates the status flags.
// RULE7: Multiplier turns two 8-bit operands into a 16-bit product.
// RULE8: Unsigned, signed and mixed multiplies, integer and fractional.
// RULE9: Every multiplication takes exactly two clock cycles.
// RULE10: One-word instructions plus a few two-word ones; counter steps accordingly.
// RULE11: Return addresses saved on the stack are word addresses.
// RULE12: Reset loads the stack pointer with the top SRAM address.
// RULE13: Stack pointer is two byte registers readable and writable as I/O.
// RULE14: Stack grows down; byte push decrements by one, pop increments.
// RULE15: Calls and interrupt entry push two bytes, pointer minus two.
// RULE16: Returns pop two bytes into the counter, pointer plus two.
// RULE17: Return address low byte goes first, at the higher address.
// RULE18: Low pointer write blocks interrupts four instructions or until next I/O write.
// RULE19: Status flags are not saved or restored on interrupt entry or return.
// RULE20: Software moving the stack keeps it above SRAM start, before calls.
// RULE21: Working registers stay readable and writable while halted for debug.
// RULE22: Immediate-operand instructions reach only working registers 16 to 31.
// RULE23: Product lands in registers 1:0, low byte in register 0.
`timescale 1ns/1ns
`default_nettype none
module cfs_core #(
  parameter logic [15:0] SRAM_END = 16'h0fff
) (
  input  wire logic                  clock,
  input  wire logic                  rst_b,
  output logic [15:0]                prog_addr,
  input  wire logic [15:0]           prog_data,
  output cfs_pkg::cfs_dmem_type      dmem,
  input  wire logic [7:0]            dmem_rdata,
  input  wire logic                  irq_req,
  input  wire logic [15:0]           irq_vector,
  output logic                       irq_ack,
  input  wire logic                  dbg_halt,
  input  wire logic                  dbg_we,
  input  wire logic [4:0]            dbg_addr,
  input  wire logic [7:0]            dbg_wdata,
  output logic [7:0]                 dbg_rdata,
  output logic [7:0]                 status_flag_register,
  output logic [15:0]                stack_top_ptr
);
  typedef struct packed {
    cfs_pkg::cfs_state_type st;
    logic [15:0]            pc;
    logic                   valid;
    logic [15:0]            sp;
    logic [7:0]             sreg;
    logic [31:0][7:0]       rf;
    logic [15:0]            ret;
    logic [15:0]            tgt;
    logic [4:0]             rd;
    logic [7:0]             hi;
    logic [2:0]             blk;
    logic                   in_handler;
    logic                   is_call;
    logic                   irq_ack;
    logic [7:0]             dbg_rdata;
    cfs_pkg::cfs_dmem_type  dm;
  } cfs_core_state_type;

  if (SRAM_END < 16'h0002) begin : g_bad_sram
    $error("SRAM_END too small to hold a return address");
  end

  cfs_core_state_type        s_q;
  cfs_core_state_type        s_d;
  cfs_pkg::cfs_rr_ins_type   rr_i;
  cfs_pkg::cfs_imm_ins_type  im_i;
  cfs_pkg::cfs_flow_ins_type fl_i;
  cfs_pkg::cfs_mul_mode_type mul_mode;
  logic                      mul_start;
  logic [15:0]               mul_prod;
  logic                      mul_done;
  logic                      irq_take;
  logic                      exec;
  logic [4:0]                imm_rd;
  logic [15:0]               alu_rr;
  logic [15:0]               alu_im;

  // Returns {flags, result}; carry is left alone by the logic ops
  function automatic logic [15:0] alu_f(input logic [1:0] fn, input logic [7:0] a,
                                        input logic [7:0] b, input logic [7:0] sr);
    logic [8:0] w;
    logic [7:0] f;
    logic       arith;
    f = sr;
    arith = (fn == cfs_pkg::ALU_ADD) || (fn == cfs_pkg::ALU_SUB);
    unique case (fn)
      cfs_pkg::ALU_ADD: w = {1'b0, a} + {1'b0, b};
      cfs_pkg::ALU_SUB: w = {1'b0, a} - {1'b0, b};
      cfs_pkg::ALU_AND: w = {1'b0, a & b};
      cfs_pkg::ALU_OR:  w = {1'b0, a | b};
    endcase
    f[cfs_pkg::FLAG_Z] = (w[7:0] == 8'h00); // RULE6
    f[cfs_pkg::FLAG_N] = w[7];
    if (fn == cfs_pkg::ALU_ADD) begin
      f[cfs_pkg::FLAG_V] = (a[7] == b[7]) && (w[7] != a[7]);
    end else if (fn == cfs_pkg::ALU_SUB) begin
      f[cfs_pkg::FLAG_V] = (a[7] != b[7]) && (w[7] != a[7]);
    end else begin
      f[cfs_pkg::FLAG_V] = 1'b0;
    end
    if (arith) begin
      f[cfs_pkg::FLAG_C] = w[8];
    end
    f[cfs_pkg::FLAG_S] = f[cfs_pkg::FLAG_N] ^ f[cfs_pkg::FLAG_V];
    return {f, w[7:0]};
  endfunction : alu_f

  assign rr_i   = cfs_pkg::cfs_rr_ins_type'(prog_data);
  assign im_i   = cfs_pkg::cfs_imm_ins_type'(prog_data);
  assign fl_i   = cfs_pkg::cfs_flow_ins_type'(prog_data);
  assign imm_rd = {1'b1, im_i.rd}; // RULE22
  assign alu_rr = alu_f(rr_i.sub, s_q.rf[rr_i.rd], s_q.rf[rr_i.rr], s_q.sreg); // RULE4
  assign irq_take = s_q.st == cfs_pkg::ST_RUN && s_q.valid && !dbg_halt && irq_req
                    && s_q.sreg[cfs_pkg::FLAG_I] && !s_q.in_handler
                    && s_q.blk == 3'h0; // RULE18
  assign exec = s_q.st == cfs_pkg::ST_RUN && s_q.valid && !dbg_halt && !irq_take;

  always_comb begin
    unique case (im_i.op)
      cfs_pkg::OP_SUBI, cfs_pkg::OP_CPI: alu_im = alu_f(cfs_pkg::ALU_SUB, s_q.rf[imm_rd],
                                                        im_i.k, s_q.sreg);
      cfs_pkg::OP_ANDI: alu_im = alu_f(cfs_pkg::ALU_AND, s_q.rf[imm_rd], im_i.k, s_q.sreg);
      default:          alu_im = alu_f(cfs_pkg::ALU_OR, s_q.rf[imm_rd], im_i.k, s_q.sreg);
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.irq_ack = 1'b0;
    s_d.dm = '0;
    s_d.dbg_rdata = s_q.rf[dbg_addr];
    mul_start = 1'b0;
    mul_mode = '0;
    mul_mode.frac = (rr_i.op == cfs_pkg::OP_FMUL);
    unique case (rr_i.sub)
      cfs_pkg::MUL_SS: begin
        mul_mode.signed_a = 1'b1;
        mul_mode.signed_b = 1'b1;
      end
      cfs_pkg::MUL_SU: mul_mode.signed_a = 1'b1;
      default: ;
    endcase
    unique case (s_q.st)
      cfs_pkg::ST_RUN: begin
        if (dbg_halt) begin
          // Halted: only the debug path touches the register file
          if (dbg_we) begin
            s_d.rf[dbg_addr] = dbg_wdata; // RULE21
          end
        end else if (!s_q.valid) begin
          // Bubble after a change of flow: the new word is still in flight
          s_d.pc = s_q.pc + 16'h0001;
          s_d.valid = 1'b1;
        end else if (irq_take) begin
          // Current word is dropped and re-fetched on return
          s_d.ret = s_q.pc - 16'h0001;
          s_d.tgt = irq_vector;
          s_d.in_handler = 1'b1;
          s_d.irq_ack = 1'b1;
          s_d.st = cfs_pkg::ST_PUSH_LO;
        end else begin
          s_d.pc = s_q.pc + 16'h0001; // RULE2
          if (s_q.blk != 3'h0) begin
            s_d.blk = s_q.blk - 3'h1; // RULE18
          end
          unique case (rr_i.op)
            cfs_pkg::OP_NOP: ;
            cfs_pkg::OP_ALU: {s_d.sreg, s_d.rf[rr_i.rd]} = alu_rr; // RULE5 RULE6
            cfs_pkg::OP_SUBI, cfs_pkg::OP_ANDI, cfs_pkg::OP_ORI:
              {s_d.sreg, s_d.rf[imm_rd]} = alu_im; // RULE5 RULE22
            cfs_pkg::OP_CPI: s_d.sreg = alu_im[15:8]; // RULE6
            cfs_pkg::OP_LDI: s_d.rf[imm_rd] = im_i.k; // RULE22
            cfs_pkg::OP_MUL, cfs_pkg::OP_FMUL: begin
              mul_start = 1'b1; // RULE9
              s_d.pc = s_q.pc;
              s_d.st = cfs_pkg::ST_MUL;
            end
            cfs_pkg::OP_PUSH: begin
              s_d.dm.addr = s_q.sp;
              s_d.dm.wdata = s_q.rf[rr_i.rr];
              s_d.dm.we = 1'b1;
              s_d.sp = s_q.sp - 16'h0001; // RULE14
            end
            cfs_pkg::OP_POP: begin
              s_d.dm.addr = s_q.sp + 16'h0001;
              s_d.dm.re = 1'b1;
              s_d.sp = s_q.sp + 16'h0001; // RULE14
              s_d.rd = rr_i.rd;
              s_d.pc = s_q.pc;
              s_d.st = cfs_pkg::ST_POP_A;
            end
            cfs_pkg::OP_CALL: begin
              s_d.is_call = 1'b1; // RULE10
              s_d.pc = s_q.pc;
              s_d.st = cfs_pkg::ST_FAR;
            end
            cfs_pkg::OP_RELCALL: begin
              s_d.ret = s_q.pc; // RULE11
              s_d.tgt = s_q.pc + {{4{prog_data[11]}}, prog_data[11:0]};
              s_d.st = cfs_pkg::ST_PUSH_LO;
            end
            cfs_pkg::OP_FLOW: begin
              unique case (fl_i.sub)
                cfs_pkg::FL_INDCALL: begin
                  s_d.ret = s_q.pc;
                  s_d.tgt = {s_q.rf[31], s_q.rf[30]};
                  s_d.st = cfs_pkg::ST_PUSH_LO;
                end
                cfs_pkg::FL_RET, cfs_pkg::FL_IRQ_RETURN: begin
                  // Flags are left as the handler made them
                  s_d.dm.addr = s_q.sp + 16'h0001; // RULE16 RULE19
                  s_d.dm.re = 1'b1;
                  s_d.pc = s_q.pc;
                  s_d.st = cfs_pkg::ST_RET_A;
                  if (fl_i.sub == cfs_pkg::FL_IRQ_RETURN) begin
                    s_d.in_handler = 1'b0;
                  end
                end
                cfs_pkg::FL_JMP: begin
                  s_d.is_call = 1'b0; // RULE10
                  s_d.pc = s_q.pc;
                  s_d.st = cfs_pkg::ST_FAR;
                end
                cfs_pkg::FL_BRZ: begin
                  if (s_q.sreg[cfs_pkg::FLAG_Z]) begin
                    s_d.pc = s_q.pc + {{8{fl_i.off[7]}}, fl_i.off};
                    s_d.valid = 1'b0;
                  end
                end
                default: ;
              endcase
            end
            cfs_pkg::OP_OUT: begin
              // Any other I/O write ends the interrupt hold early
              s_d.blk = 3'h0; // RULE18
              unique case (rr_i.rr)
                cfs_pkg::IO_SP_LOW: begin
                  s_d.sp[7:0] = s_q.rf[rr_i.rd]; // RULE13
                  s_d.blk = cfs_pkg::IRQ_BLOCK_INSNS; // RULE18
                end
                cfs_pkg::IO_SP_HIGH: s_d.sp[15:8] = s_q.rf[rr_i.rd]; // RULE13
                cfs_pkg::IO_SREG:    s_d.sreg = s_q.rf[rr_i.rd];
                default: ;
              endcase
            end
            cfs_pkg::OP_IN: begin
              unique case (rr_i.rr)
                cfs_pkg::IO_SP_LOW:  s_d.rf[rr_i.rd] = s_q.sp[7:0]; // RULE13
                cfs_pkg::IO_SP_HIGH: s_d.rf[rr_i.rd] = s_q.sp[15:8]; // RULE13
                cfs_pkg::IO_SREG:    s_d.rf[rr_i.rd] = s_q.sreg;
                default:             s_d.rf[rr_i.rd] = 8'h00;
              endcase
            end
          endcase
        end
      end
      cfs_pkg::ST_MUL: begin
        if (mul_done) begin
          {s_d.rf[1], s_d.rf[0]} = mul_prod; // RULE23
          s_d.sreg[cfs_pkg::FLAG_C] = mul_prod[15];
          s_d.sreg[cfs_pkg::FLAG_Z] = (mul_prod == 16'h0000);
          s_d.pc = s_q.pc + 16'h0001;
          s_d.st = cfs_pkg::ST_RUN;
        end
      end
      cfs_pkg::ST_FAR: begin
        // Second word is the absolute target
        s_d.tgt = prog_data; // RULE10
        s_d.ret = s_q.pc + 16'h0001; // RULE11
        if (s_q.is_call) begin
          s_d.st = cfs_pkg::ST_PUSH_LO;
        end else begin
          s_d.pc = prog_data;
          s_d.valid = 1'b0;
          s_d.st = cfs_pkg::ST_RUN;
        end
      end
      cfs_pkg::ST_PUSH_LO: begin
        s_d.dm.addr = s_q.sp;
        s_d.dm.wdata = s_q.ret[7:0]; // RULE17
        s_d.dm.we = 1'b1;
        s_d.sp = s_q.sp - 16'h0001;
        s_d.st = cfs_pkg::ST_PUSH_HI;
      end
      cfs_pkg::ST_PUSH_HI: begin
        s_d.dm.addr = s_q.sp;
        s_d.dm.wdata = s_q.ret[15:8]; // RULE17
        s_d.dm.we = 1'b1;
        s_d.sp = s_q.sp - 16'h0001; // RULE15
        s_d.pc = s_q.tgt;
        s_d.valid = 1'b0;
        s_d.st = cfs_pkg::ST_RUN;
      end
      cfs_pkg::ST_POP_A: s_d.st = cfs_pkg::ST_POP_WB;
      cfs_pkg::ST_POP_WB: begin
        s_d.rf[s_q.rd] = dmem_rdata;
        s_d.pc = s_q.pc + 16'h0001;
        s_d.st = cfs_pkg::ST_RUN;
      end
      cfs_pkg::ST_RET_A: begin
        s_d.dm.addr = s_q.sp + 16'h0002;
        s_d.dm.re = 1'b1;
        s_d.st = cfs_pkg::ST_RET_B;
      end
      cfs_pkg::ST_RET_B: begin
        s_d.hi = dmem_rdata;
        s_d.st = cfs_pkg::ST_RET_C;
      end
      cfs_pkg::ST_RET_C: begin
        s_d.pc = {s_q.hi, dmem_rdata}; // RULE16
        s_d.sp = s_q.sp + 16'h0002; // RULE16
        s_d.valid = 1'b0;
        s_d.st = cfs_pkg::ST_RUN;
      end
      default: s_d.st = cfs_pkg::ST_RUN;
    endcase
  end

  // Everything runs on the undivided core clock
  always_ff @(posedge clock) begin // RULE3
    if (!rst_b) begin
      s_q <= '0;
      s_q.pc <= cfs_pkg::RESET_PC; // RULE1
      s_q.sp <= SRAM_END; // RULE12
    end else begin
      s_q <= s_d;
    end
  end

  cfs_mult u_mult (
    .clock   (clock),
    .rst_b   (rst_b),
    .start   (mul_start),
    .mode    (mul_mode),
    .a       (s_q.rf[rr_i.rd]),
    .b       (s_q.rf[rr_i.rr]),
    .product (mul_prod),
    .done    (mul_done)
  );

  assign prog_addr            = s_q.pc;
  assign dmem                 = s_q.dm;
  assign irq_ack              = s_q.irq_ack;
  assign dbg_rdata            = s_q.dbg_rdata;
  assign status_flag_register = s_q.sreg;
  assign stack_top_ptr        = s_q.sp;

  chk_reset_start: assert property (@(posedge clock) disable iff (!rst_b) // RULE1 RULE12
    $rose(rst_b) |-> prog_addr == cfs_pkg::RESET_PC && stack_top_ptr == SRAM_END)
    else $error("bad state after reset");
  chk_pipe_step: assert property (@(posedge clock) disable iff (!rst_b) // RULE2
    exec && rr_i.op == cfs_pkg::OP_NOP |=> prog_addr == $past(prog_addr) + 16'h0001)
    else $error("prefetch did not advance");
  chk_add_single: assert property (@(posedge clock) disable iff (!rst_b) // RULE5
    exec && rr_i.op == cfs_pkg::OP_ALU && rr_i.sub == cfs_pkg::ALU_ADD
    |=> s_q.rf[$past(rr_i.rd)] == $past(s_q.rf[rr_i.rd] + s_q.rf[rr_i.rr]))
    else $error("add result not written in one cycle");
  chk_zero_flag: assert property (@(posedge clock) disable iff (!rst_b) // RULE6
    exec && rr_i.op == cfs_pkg::OP_ALU
    |=> s_q.sreg[cfs_pkg::FLAG_Z] == (s_q.rf[$past(rr_i.rd)] == 8'h00))
    else $error("zero flag disagrees with result");
  chk_mul_two: assert property (@(posedge clock) disable iff (!rst_b) // RULE9 RULE23
    mul_start |=> s_q.st == cfs_pkg::ST_MUL ##1 {s_q.rf[1], s_q.rf[0]} == mul_prod)
    else $error("product not in place after two cycles");
  chk_call_order: assert property (@(posedge clock) disable iff (!rst_b) // RULE17 RULE15
    s_q.st == cfs_pkg::ST_PUSH_LO
    |=> dmem.we && dmem.wdata == $past(s_q.ret[7:0]) && dmem.addr == $past(s_q.sp)
    ##1 dmem.we && dmem.addr == $past(s_q.sp, 2) - 16'h0001
    && s_q.sp == $past(s_q.sp, 2) - 16'h0002)
    else $error("return address push out of order");
  chk_ret_sp: assert property (@(posedge clock) disable iff (!rst_b) // RULE16
    s_q.st == cfs_pkg::ST_RET_C |=> s_q.sp == $past(s_q.sp) + 16'h0002 && !s_q.valid)
    else $error("return did not restore pointer");
  chk_push_one: assert property (@(posedge clock) disable iff (!rst_b) // RULE14
    exec && rr_i.op == cfs_pkg::OP_PUSH |=> s_q.sp == $past(s_q.sp) - 16'h0001)
    else $error("push did not decrement pointer");
  chk_irq_hold: assert property (@(posedge clock) disable iff (!rst_b) // RULE18
    irq_ack |-> $past(s_q.blk) == 3'h0) else $error("interrupt taken while held off");
  chk_sreg_kept: assert property (@(posedge clock) disable iff (!rst_b) // RULE19
    irq_ack |-> status_flag_register == $past(status_flag_register))
    else $error("flags changed on interrupt entry");
  chk_dbg_write: assert property (@(posedge clock) disable iff (!rst_b) // RULE21
    s_q.st == cfs_pkg::ST_RUN && dbg_halt && dbg_we
    |=> s_q.rf[$past(dbg_addr)] == $past(dbg_wdata))
    else $error("debug write lost");

endmodule : cfs_core
`default_nettype wire

// ==== tb/cfs_mem_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module cfs_mem_model (
  input  wire logic                  clock,
  input  wire logic [15:0]           prog_addr,
  output var logic [15:0]            prog_data,
  input  wire cfs_pkg::cfs_dmem_type dmem,
  output logic [7:0]                 dmem_rdata
);
  logic [15:0] rom [0:255];
  logic [7:0]  ram [0:255];
  logic [7:0]  rd_a;
  logic        rd_v;
  logic [7:0]  last;
  // Synchronous program memory: word appears one cycle after its address
  always_ff @(posedge clock) begin
    prog_data <= rom[prog_addr[7:0]];
    rd_v      <= dmem.re;
    rd_a      <= dmem.addr[7:0];
    if (rd_v) last <= ram[rd_a];
    if (dmem.we) ram[dmem.addr[7:0]] <= dmem.wdata;
  end
  // Outside a read slot the bus shows junk, so a late sample cannot pass by luck
  assign dmem_rdata = rd_v ? ram[rd_a] : ~last;
endmodule : cfs_mem_model
`default_nettype wire

// ==== tb/cfs_core_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module cfs_core_tb;
  localparam logic [15:0] END = 16'h00ff;
  logic clock, rst_b, irq_req, irq_ack, dbg_halt, dbg_we;
  logic [15:0] prog_addr, prog_data, irq_vector, sp;
  logic [4:0]  dbg_addr;
  logic [7:0]  dbg_wdata, dbg_rdata, dmem_rdata, flags;
  cfs_pkg::cfs_dmem_type dmem;
  int          num_errors, check_count;
  logic [15:0] wq [$];

  cfs_core #(.SRAM_END(END)) dut (.clock(clock), .rst_b(rst_b), .prog_addr(prog_addr),
    .prog_data(prog_data), .dmem(dmem), .dmem_rdata(dmem_rdata), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_ack(irq_ack), .dbg_halt(dbg_halt), .dbg_we(dbg_we),
    .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata), .dbg_rdata(dbg_rdata),
    .status_flag_register(flags), .stack_top_ptr(sp));
  cfs_mem_model mem (.clock(clock), .prog_addr(prog_addr), .prog_data(prog_data),
    .dmem(dmem), .dmem_rdata(dmem_rdata));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  always @(posedge clock) if (dmem.we === 1'b1) wq.push_back(dmem.addr);

  task summarize;
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  task check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task load(input logic [15:0] w [$]);
    foreach (mem.rom[i]) mem.rom[i] = 16'h0000;
    foreach (w[i]) mem.rom[i] = w[i];
  endtask : load

  task start;
    wq.delete();
    rst_b <= 1'b0;
    repeat (3) @(posedge clock);
    #1 check(prog_addr, 16'h0000);
    check(sp, END);
    check({8'h00, flags}, 16'h0000);
    @(posedge clock) rst_b <= 1'b1;
    #1;
  endtask : start

  task wait_pc(input logic [15:0] a);
    for (int i = 0; i < 200 && prog_addr !== a; i++) @(posedge clock) #1;
    check(prog_addr, a);
  endtask : wait_pc

  task dbg_rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge clock) dbg_addr <= a;
    repeat (2) @(posedge clock);
    #1 check({8'h00, dbg_rdata}, {8'h00, e});
  endtask : dbg_rd

  task t_alu;
    load('{16'h707f, 16'h7103, 16'h1211, 16'hf242, 16'h1631, 16'hf262});
    start;
    wait_pc(16'h0008);
    @(posedge clock) dbg_halt <= 1'b1;
    @(posedge clock) begin
      dbg_addr  <= 5'd20;
      dbg_wdata <= 8'h5a;
      dbg_we    <= 1'b1;
    end
    @(posedge clock) dbg_we <= 1'b0;
    dbg_rd(5'd16, 8'h82);
    dbg_rd(5'd17, 8'h00);
    dbg_rd(5'd18, 8'h0c);
    dbg_rd(5'd19, 8'h02);
    dbg_rd(5'd20, 8'h5a);
    dbg_halt <= 1'b0;
  endtask : t_alu

  task t_mul;
    logic [15:0] w [$];
    logic [15:0] p [6];
    logic [15:0] pa;
    int          st;
    p  = '{16'h81fa, 16'h00fa, 16'hfefa, 16'h03f4, 16'h01f4, 16'hfdf4};
    w  = '{16'h70fe, 16'h7183};
    st = 0;
    for (int k = 0; k < 6; k++) begin
      w.push_back({(k < 3) ? 4'h2 : 4'h3, 2'(k % 3), 10'h211});
      w.push_back(16'h9000);
      w.push_back(16'h9001);
    end
    load(w);
    start;
    // One hold of the fetch address per multiply, none elsewhere
    for (int i = 0; i < 100 && prog_addr !== 16'd22; i++) begin
      pa = prog_addr;
      @(posedge clock) #1;
      if (prog_addr === pa) st++;
    end
    check(16'(st), 16'd6);
    for (int k = 0; k < 6; k++)
      check({mem.ram[END - 2 * k - 1], mem.ram[END - 2 * k]}, p[k]);
    check(sp, END - 16'd12);
  endtask : t_mul

  task t_call;
    logic [15:0] w [$];
    w = '{16'hb000, 16'h0010};
    for (int i = 2; i < 16; i++) w.push_back(16'h0000);
    w.push_back(16'hd100);
    load(w);
    start;
    wait_pc(16'h0011);
    check(sp, END - 16'd2);
    check(wq[0], END);
    check(wq[1], END - 16'd1);
    check({mem.ram[END - 1], mem.ram[END]}, 16'h0002);
    wait_pc(16'h0004);
    check(sp, END);
  endtask : t_call

  task t_irq;
    logic [15:0] w [$];
    // Stack moved while interrupts are still off, then re-written with them on
    w = '{16'h70f0, 16'he200, 16'h7180, 16'he222, 16'he200};
    for (int i = 5; i < 32; i++) w.push_back(16'h0000);
    w.push_back(16'hd200);
    load(w);
    start;
    wait_pc(16'h0006);
    irq_vector <= 16'h0020;
    @(posedge clock) irq_req <= 1'b1;
    for (int i = 0; i < 20 && irq_ack !== 1'b1; i++) @(posedge clock) #1;
    check({15'h0000, irq_ack}, 16'h0001);
    @(posedge clock) irq_req <= 1'b0;
    wait_pc(16'h000b);
    check({mem.ram[8'hef], mem.ram[8'hf0]}, 16'h0009);
    check(sp, 16'h00f0);
    check({8'h00, flags}, 16'h0080);
  endtask : t_irq

  // Immediate ops, taken branch, pop, relative and indirect calls; ends in a branch loop
  task t_misc;
    load('{16'h703c, 16'h400c, 16'h501f, 16'h6105, 16'h8105, 16'hd402, 16'h7155, 16'h7155,
      16'h9010, 16'ha240, 16'hc004, 16'hf280, 16'hd4ff, 16'h0000, 16'h0000, 16'h7e14,
      16'hd000, 16'hd100, 16'h0000, 16'h0000, 16'hd100});
    start;
    wait_pc(16'h000d);
    check(sp, END);
    check(wq[4], END - 16'd3);
    check({mem.ram[END - 1], mem.ram[END]}, 16'h000b);
    check({mem.ram[END - 3], mem.ram[END - 2]}, 16'h0011);
    check({8'h00, flags}, 16'h0002);
    @(posedge clock) dbg_halt <= 1'b1;
    dbg_rd(5'd16, 8'h10);
    dbg_rd(5'd17, 8'h05);
    dbg_rd(5'd18, 8'h10);
    dbg_rd(5'd20, 8'hff);
    dbg_halt <= 1'b0;
  endtask : t_misc

  initial begin
    #(2000 * 100);
    num_errors++;
    summarize;
  end

  initial begin
    rst_b      = 1'b0;
    irq_req    = 1'b0;
    irq_vector = 16'h0000;
    dbg_halt   = 1'b0;
    dbg_we     = 1'b0;
    dbg_addr   = 5'h00;
    dbg_wdata  = 8'h00;
    t_alu;
    t_mul;
    t_call;
    t_irq;
    t_misc;
    summarize;
  end
endmodule : cfs_core_tb
`default_nettype wire
